// [hw/pirq_flags.sv]
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pirq_map.svh"

// Overview of operation
// - Eight-bit flag register at 0x0C, resets zero
// - Bit 7 sets on host port access, except when the small-package control bit is set
// - Bit 6 sets on conversion done
// - Bit 5 mirrors receive buffer full, read-only
// - Bit 4 mirrors transmit buffer empty, read-only
// - Bit 3 sets on serial port event
// - Two-wire master condition completions also set bit 3
// - Bit 2 on capture or compare, never PWM
// - Bit 1 sets on period match
// - Bit 0 sets on wide timer rollover
// - Flags set regardless of any enable
// - Request needs enable bit and peripheral gate
module pirq_flags (
    input  wire logic                    clk_in,
    input  wire logic                    arst_n_in,
    input  wire logic [`PIRQ_AW-1:0]     avs_address_in,
    input  wire logic                    avs_read_in,
    input  wire logic                    avs_write_in,
    input  wire logic [`PIRQ_DW-1:0]     avs_writedata_in,
    input  wire logic [3:0]              avs_byteenable_in,
    output logic      [`PIRQ_DW-1:0]     avs_readdata_out,
    output logic                         avs_waitrequest_out,
    output logic      [1:0]              avs_response_out,
    input  wire pirq_pkg::pirq_evt_t     evt_in,
    input  wire pirq_pkg::pirq_twi_t     twi_in,
    input  wire pirq_pkg::pirq_ccp_mode_t ccp_mode_in,
    output logic                         periph_irq_req_out,
    output logic                         global_irq_req_out,
    output logic                         irq_out
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic hit(
        input logic [`PIRQ_AW-1:0] addr,
        input logic [`PIRQ_AW-1:0] off
    );
        hit = (addr == off);
    endfunction

    function automatic logic [`PIRQ_FW-1:0] merge_w1c(
        input logic [`PIRQ_FW-1:0] cur,
        input logic [`PIRQ_FW-1:0] clr,
        input logic [`PIRQ_FW-1:0] set
    );
        merge_w1c = (cur & ~clr) | set;
    endfunction

    function automatic logic rise(
        input logic now_lvl,
        input logic prev_lvl
    );
        rise = now_lvl && !prev_lvl;
    endfunction

    function automatic logic any_pending(
        input logic [`PIRQ_FW-1:0] flags,
        input logic [`PIRQ_FW-1:0] enables
    );
        any_pending = |(flags & enables);
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [`PIRQ_FW-1:0] peripheral_event_flags;
    logic [`PIRQ_FW-1:0] peripheral_event_enables;
    logic [`PIRQ_FW-1:0] ctrl;
    logic [`PIRQ_FW-1:0] irq_status;
    logic [`PIRQ_FW-1:0] irq_mask;
    logic                rx_full_q;
    logic                tx_empty_q;

    logic [`PIRQ_FW-1:0] next_flags;
    logic [`PIRQ_FW-1:0] next_status;
    logic [`PIRQ_FW-1:0] set_vec;
    logic [`PIRQ_FW-1:0] evt_vec;
    logic [`PIRQ_DW-1:0] rd_word;
    logic                rd_mapped;
    logic                acc_take;
    logic                acc_wr;
    logic                lane0;
    logic                sync_set;
    logic                ccp_set;
    logic                wr_flags;
    logic                wr_enables;
    logic                wr_ctrl;
    logic                wr_status;
    logic                wr_mask;

    // ****************************************
    // Bus handshake
    // ****************************************
    // Answer one cycle after the request, so read data stands early
    assign acc_take = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
    assign acc_wr   = acc_take && avs_write_in;
    assign lane0    = avs_byteenable_in[0];

    // Lane 0 alone carries every register; upper lanes are ignored
    assign wr_flags   = acc_wr && lane0 && hit(avs_address_in, `PIRQ_OFF_FLAGS);
    assign wr_enables = acc_wr && lane0 && hit(avs_address_in, `PIRQ_OFF_ENABLES);
    assign wr_ctrl    = acc_wr && lane0 && hit(avs_address_in, `PIRQ_OFF_CTRL);
    assign wr_status  = acc_wr && lane0 && hit(avs_address_in, `PIRQ_OFF_STATUS);
    assign wr_mask    = acc_wr && lane0 && hit(avs_address_in, `PIRQ_OFF_MASK);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if (acc_take) begin
            avs_waitrequest_out <= 1'b1;
        end else if (avs_read_in || avs_write_in) begin
            avs_waitrequest_out <= 1'b0;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    always_comb begin
        rd_word   = `PIRQ_RST_WORD;
        rd_mapped = 1'b1;
        case (1'b1)
            hit(avs_address_in, `PIRQ_OFF_FLAGS):
                rd_word[`PIRQ_FW-1:0] = peripheral_event_flags;
            hit(avs_address_in, `PIRQ_OFF_ENABLES):
                rd_word[`PIRQ_FW-1:0] = peripheral_event_enables;
            hit(avs_address_in, `PIRQ_OFF_CTRL):
                rd_word[`PIRQ_FW-1:0] = ctrl;
            hit(avs_address_in, `PIRQ_OFF_STATUS):
                rd_word[`PIRQ_FW-1:0] = irq_status;
            hit(avs_address_in, `PIRQ_OFF_MASK):
                rd_word[`PIRQ_FW-1:0] = irq_mask;
            default:
                rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            avs_readdata_out <= `PIRQ_RST_WORD;
            avs_response_out <= `PIRQ_RESP_OK;
        end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
            avs_readdata_out <= avs_read_in ? rd_word : `PIRQ_RST_WORD;
            avs_response_out <= rd_mapped ? `PIRQ_RESP_OK : `PIRQ_RESP_DECERR;
        end
    end

    // ****************************************
    // Event sources
    // ****************************************
    // Serial port events
    assign sync_set = evt_in.sync_xfer_done
        || (twi_in.master_mode && (twi_in.start_done || twi_in.stop_done
            || twi_in.restart_done || twi_in.ack_done
            || twi_in.start_idle || twi_in.stop_idle));

    always_comb begin
        case (ccp_mode_in)
            pirq_pkg::PIRQ_CCP_CAPTURE: ccp_set = evt_in.ccp_capture;
            pirq_pkg::PIRQ_CCP_COMPARE: ccp_set = evt_in.ccp_match;
            pirq_pkg::PIRQ_CCP_PWM:     ccp_set = 1'b0;
            default:                    ccp_set = 1'b0;
        endcase
    end

    always_comb begin
        set_vec = `PIRQ_RST_BYTE;
        // Host port, unused on small package
        set_vec[`PIRQ_BIT_HOST] = evt_in.host_access && !ctrl[`PIRQ_CTRL_SMALL];
        set_vec[`PIRQ_BIT_CONV]  = evt_in.conv_done;
        set_vec[`PIRQ_BIT_SYNC]  = sync_set;
        set_vec[`PIRQ_BIT_CCP]   = ccp_set;
        set_vec[`PIRQ_BIT_MATCH] = evt_in.period_match;
        set_vec[`PIRQ_BIT_WIDE]  = evt_in.wide_rollover;
    end

    // Buffer bits raise a sticky event only on their rising edge
    always_comb begin
        evt_vec = set_vec;
        evt_vec[`PIRQ_BIT_RX] = rise(evt_in.rx_full, rx_full_q);
        evt_vec[`PIRQ_BIT_TX] = rise(evt_in.tx_empty, tx_empty_q);
    end

    // ****************************************
    // Flag register
    // ****************************************
    // Set wins over clear
    always_comb begin
        next_flags = peripheral_event_flags;
        if (wr_flags) begin
            next_flags = avs_writedata_in[`PIRQ_FW-1:0] & `PIRQ_SW_MASK;
        end
        next_flags = (next_flags & `PIRQ_SW_MASK) | set_vec;
        next_flags[`PIRQ_BIT_RX] = evt_in.rx_full;
        next_flags[`PIRQ_BIT_TX] = evt_in.tx_empty;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            peripheral_event_flags <= `PIRQ_RST_BYTE;
        end else begin
            peripheral_event_flags <= next_flags;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // Transmit buffer idles empty, so no false edge after reset
            rx_full_q  <= 1'b0;
            tx_empty_q <= 1'b1;
        end else begin
            rx_full_q  <= evt_in.rx_full;
            tx_empty_q <= evt_in.tx_empty;
        end
    end

    // ****************************************
    // Enables and control
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            peripheral_event_enables <= `PIRQ_RST_BYTE;
        end else if (wr_enables) begin
            peripheral_event_enables <= avs_writedata_in[`PIRQ_FW-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl <= `PIRQ_RST_BYTE;
        end else if (wr_ctrl) begin
            ctrl <= avs_writedata_in[`PIRQ_FW-1:0] & `PIRQ_CTRL_MASK;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    // New event beats write-one clear
    always_comb begin
        next_status = merge_w1c(irq_status, `PIRQ_RST_BYTE, evt_vec);
        if (wr_status) begin
            next_status = merge_w1c(irq_status,
                avs_writedata_in[`PIRQ_FW-1:0], evt_vec);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_status <= `PIRQ_RST_BYTE;
        end else begin
            irq_status <= next_status;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_mask <= `PIRQ_RST_BYTE;
        end else if (wr_mask) begin
            irq_mask <= avs_writedata_in[`PIRQ_FW-1:0];
        end
    end

    // ****************************************
    // Request outputs
    // ****************************************
    // Registered from next state so outputs track flags exactly
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= any_pending(next_status, irq_mask);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            periph_irq_req_out <= 1'b0;
            global_irq_req_out <= 1'b0;
        end else begin
            periph_irq_req_out <= ctrl[`PIRQ_CTRL_PERIPHERAL_IRQ_GATE]
                && any_pending(next_flags, peripheral_event_enables);
            global_irq_req_out <= ctrl[`PIRQ_CTRL_GIE] && ctrl[`PIRQ_CTRL_PERIPHERAL_IRQ_GATE]
                && any_pending(next_flags, peripheral_event_enables);
        end
    end

endmodule
`default_nettype wire

// [hw/pirq_map.svh]
`ifndef PIRQ_MAP_SVH
`define PIRQ_MAP_SVH

`define PIRQ_AW           8
`define PIRQ_DW           32
`define PIRQ_FW           8
`define PIRQ_OFF_FLAGS    8'h0C
`define PIRQ_OFF_ENABLES  8'h10
`define PIRQ_OFF_CTRL     8'h14
`define PIRQ_OFF_STATUS   8'h18
`define PIRQ_OFF_MASK     8'h1C

`define PIRQ_BIT_HOST     7
`define PIRQ_BIT_CONV     6
`define PIRQ_BIT_RX       5
`define PIRQ_BIT_TX       4
`define PIRQ_BIT_SYNC     3
`define PIRQ_BIT_CCP      2
`define PIRQ_BIT_MATCH    1
`define PIRQ_BIT_WIDE     0

`define PIRQ_CTRL_PERIPHERAL_IRQ_GATE    0
`define PIRQ_CTRL_GIE     1
`define PIRQ_CTRL_SMALL   2
`define PIRQ_CTRL_MASK    8'h07

`define PIRQ_SW_MASK      8'hCF
`define PIRQ_RST_BYTE     8'h00
`define PIRQ_RST_WORD     32'h0000_0000
`define PIRQ_RESP_OK      2'h0
`define PIRQ_RESP_DECERR  2'h3

`endif

// [hw/pirq_pkg.sv]
package pirq_pkg;

    typedef enum logic [1:0] {
        PIRQ_CCP_OFF,
        PIRQ_CCP_CAPTURE,
        PIRQ_CCP_COMPARE,
        PIRQ_CCP_PWM
    } pirq_ccp_mode_t;

    typedef struct packed {
        logic host_access;
        logic conv_done;
        logic rx_full;
        logic tx_empty;
        logic sync_xfer_done;
        logic ccp_capture;
        logic ccp_match;
        logic period_match;
        logic wide_rollover;
    } pirq_evt_t;

    typedef struct packed {
        logic master_mode;
        logic start_done;
        logic stop_done;
        logic restart_done;
        logic ack_done;
        logic start_idle;
        logic stop_idle;
    } pirq_twi_t;

endpackage

// [dv/pirq_flags_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************
// Bus and request checks
// ****************
module pirq_flags_properties (
    input wire logic        clk_in,
    input wire logic        arst_n_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic [1:0]  avs_response_out,
    input wire logic        periph_irq_req_out,
    input wire logic        global_irq_req_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire logic hit = avs_address_in inside {8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    wire logic idle = !avs_read_in && !avs_write_in;
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_ans;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    a_one_wait: assert property (s_req |=> s_ans)
        else $error("wait state not one cycle");
    a_idle_quiet: assert property (idle && avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer without request");
    a_decode_err: assert property ((s_req and (avs_read_in && !hit))
        |=> avs_response_out == 2'h3)
        else $error("unmapped read not refused");
    a_mapped_ok: assert property ((s_req and hit) |=> avs_response_out == 2'h0)
        else $error("mapped access refused");
    a_upper_zero: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
        else $error("upper read bits set");
    a_write_zero: assert property ((s_req and avs_write_in) |=> avs_readdata_out == 32'h0)
        else $error("write returned data");
    a_data_stands: assert property (s_req ##1 !avs_waitrequest_out
        |=> $stable(avs_readdata_out))
        else $error("read data moved");
    a_global_gated: assert property (global_irq_req_out |-> periph_irq_req_out)
        else $error("global request without gate");
endmodule
bind pirq_flags pirq_flags_properties u_props (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .periph_irq_req_out(periph_irq_req_out),
    .global_irq_req_out(global_irq_req_out)
);
`default_nettype wire

// [dv/pirq_periph_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************
// Peripheral sources
// ****************
module pirq_periph_model (
    input  wire logic           clk_in,
    output pirq_pkg::pirq_evt_t evt_out,
    output pirq_pkg::pirq_twi_t twi_out
);
    initial begin
        evt_out = 9'h020;
        twi_out = 7'h00;
    end
    task automatic pe(input int i);
        @(posedge clk_in);
        evt_out[i] <= 1'b1;
        @(posedge clk_in);
        evt_out[i] <= 1'b0;
    endtask
    task automatic pt(input int i);
        @(posedge clk_in);
        twi_out[i] <= 1'b1;
        @(posedge clk_in);
        twi_out[i] <= 1'b0;
    endtask
    task automatic lvl(input logic rx, input logic tx, input logic m);
        evt_out[6] <= rx;
        evt_out[5] <= tx;
        twi_out[6] <= m;
    endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
// ****************
// Bench
// ****************
module tb_top;
    logic                     clk_in, arst_n_in, rd, wr, wq, preq, greq, irq, be0;
    logic [7:0]               adr;
    logic [31:0]              wd, rdat, rnd;
    logic [3:0]               be;
    logic [1:0]               rsp;
    logic [33:0]              e_n, r_v;
    logic [33:0]              exp_q[$];
    pirq_pkg::pirq_evt_t      evt;
    pirq_pkg::pirq_twi_t      twi;
    pirq_pkg::pirq_ccp_mode_t mode;
    int                       num_errors, n_compared;
    int                       ei[6] = '{8, 7, 4, 3, 1, 0};
    int                       fb[6] = '{7, 6, 3, 2, 1, 0};
    pirq_flags dut_u (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .avs_response_out(rsp),
        .evt_in(evt), .twi_in(twi), .ccp_mode_in(mode), .periph_irq_req_out(preq),
        .global_irq_req_out(greq), .irq_out(irq)
    );
    pirq_periph_model pm (.clk_in(clk_in), .evt_out(evt), .twi_out(twi));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Request held until waitrequest is seen low at an edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        logic [31:0] r;
        r = $urandom;
        @(posedge clk_in);
        adr <= a;
        // Only byte lane 0 is live; the rest carry noise
        wd <= {r[31:8], d[7:0]};
        be <= {r[3:1], be0};
        wr <= w;
        rd <= !w;
        if (!w) exp_q.push_back(e);
        do @(posedge clk_in); while (wq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [33:0] e);
        acc(1'b0, a, 32'h0, e);
    endtask
    task automatic wrx(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 34'h0);
    endtask
    // Read data taken at the edge that ends the wait
    always @(posedge clk_in) begin
        if (rd === 1'b1 && wq === 1'b0) begin
            e_n = exp_q.pop_front();
            r_v = {rsp, rdat};
            `CHK("read", e_n, r_v)
        end
    end
    task automatic results();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #50us;
        num_errors++;
        results();
    end
    initial begin
        void'($urandom(55678));
        {arst_n_in, rd, wr, adr, wd} = '0;
        be = 4'hF;
        be0 = 1'b1;
        mode = pirq_pkg::PIRQ_CCP_CAPTURE;
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rdx(8'h0C, 34'h10);
        rdx(8'h10, 34'h0);
        for (int i = 0; i < 6; i++) begin
            pm.pe(ei[i]);
            rdx(8'h0C, 34'h10 | (34'h1 << fb[i]));
            wrx(8'h0C, 32'h0);
        end
        // Capture counts only in capture mode, match only in compare mode
        for (int m = 0; m < 4; m++) begin
            mode <= pirq_pkg::pirq_ccp_mode_t'(m[1:0]);
            pm.pe(3);
            pm.pe(2);
            rdx(8'h0C, (m == 1 || m == 2) ? 34'h14 : 34'h10);
            wrx(8'h0C, 32'h0);
        end
        pm.lvl(1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 6; i++) begin
            pm.pt(i);
            rdx(8'h0C, 34'h18);
            wrx(8'h0C, 32'h0);
        end
        pm.lvl(1'b1, 1'b0, 1'b0);
        pm.pt(5);
        rdx(8'h0C, 34'h20);
        wrx(8'h0C, 32'hFF);
        rdx(8'h0C, 34'hEF);
        pm.lvl(1'b0, 1'b1, 1'b0);
        $display("event test done");
        // Pulse lands on the very edge that commits the clear
        fork
            wrx(8'h0C, 32'h0);
            begin
                @(posedge clk_in);
                pm.pe(0);
            end
        join
        rdx(8'h0C, 34'h11);
        rnd = $urandom;
        wrx(8'h10, rnd);
        rdx(8'h10, {26'h0, rnd[7:0]});
        wrx(8'h10, 32'h1);
        for (int c = 0; c < 3; c++) begin
            wrx(8'h14, (32'h1 << c) - 32'h1);
            // Requests follow a control write one edge late
            repeat (2) @(negedge clk_in);
            `CHK("periph", c != 0, preq)
            `CHK("global", c == 2, greq)
        end
        wrx(8'h14, 32'h4);
        pm.pe(8);
        rdx(8'h0C, 34'h11);
        $display("gate test done");
        wrx(8'h18, 32'hFF);
        wrx(8'h1C, 32'h1);
        pm.pe(0);
        @(negedge clk_in);
        `CHK("irq", 1'b1, irq)
        wrx(8'h1C, 32'h0);
        repeat (2) @(negedge clk_in);
        `CHK("irq", 1'b0, irq)
        wrx(8'h18, 32'h1);
        rdx(8'h18, 34'h0);
        rdx(8'h20, {2'h3, 32'h0});
        be0 = 1'b0;
        wrx(8'h10, 32'hFF);
        be0 = 1'b1;
        rdx(8'h10, 34'h1);
        // Mid-run reset brings enables and control back to zero; flags read back only the transmit-empty mirror bit
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rdx(8'h10, 34'h0);
        rdx(8'h14, 34'h0);
        rdx(8'h0C, 34'h10);
        $display("bus test done");
        results();
    end
endmodule
`default_nettype wire
